// ### design/cdpr_pkg.sv
// Constants, encodings and register map for the cascaded dual-port memory
// What this block does
// [R1] Both ports run on the single clock pclk, true dual-port mode included.
// [R2] Each tile holds 4096 words of 72 bits, not reconfigurable.
// [R3] Two ports, each able to address every location of the memory.
// [R4] Output register reset clears the output to zero only.
// [R5] Native port behaviour is no-change: output holds while that port writes.
// [R6] Single-port read-first or write-first is built from extra logic around the array.
// [R7] No preload; every location reads zero after power-up.
// [R8] Single-port mode: port A does all reads and writes.
// [R9] Simple dual-port mode: port A only writes, port B only reads.
// [R10] True dual-port mode: both ports read and write, no-change only.
// [R11] Port A acts before port B within one cycle.
// [R12] User logic never reads and writes one address in one cycle in true dual-port.
// [R13] Port enable overrides write enable.
// [R14] Byte write enables update only the selected lanes of the word.
// [R15] Full pipelining adds rows plus columns output stages.
// [R16] Rows are depth over 4096, capped by a chain height defaulting to 8.
// [R17] Tiles past the chain height start a new column.
// [R18] Width does not change rows or columns; wider data replicates the matrix.
// [R19] Global height default -1 means automatic; per-memory height wins.
// [R20] Without added stages, read data appears one edge after the request.
// [R21] The 72-bit word is eight 9-bit lanes, one byte enable each.
package cdpr_pkg;

    // Tile geometry
    localparam int TILE_WORDS     = 4096;
    localparam int TILE_BITS      = 72;
    localparam int LANE_BITS      = 9;
    localparam int LANES_PER_TILE = 8;
    localparam int DEFAULT_HEIGHT = 8;
    localparam int HEIGHT_AUTO    = -1;

    // APB register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] GEOM_OFS   = 12'h008;

    // Field positions
    localparam int CTRL_MODE_LSB    = 0;
    localparam int CTRL_WMODE_LSB   = 2;
    localparam int STATUS_READY_BIT = 0;
    localparam int STATUS_BUSY_BIT  = 1;
    localparam int GEOM_ROWS_LSB    = 0;
    localparam int GEOM_COLS_LSB    = 8;
    localparam int GEOM_STAGES_LSB  = 16;
    localparam int GEOM_COPIES_LSB  = 24;

    // Port operating modes
    typedef enum logic [1:0] {
        CDPR_SINGLE = 2'b00,
        CDPR_SIMPLE = 2'b01,
        CDPR_TRUE   = 2'b10
    } cdpr_mode_e;

    // Single-port output behaviour during a write
    typedef enum logic [1:0] {
        CDPR_NO_CHANGE   = 2'b00,
        CDPR_READ_FIRST  = 2'b01,
        CDPR_WRITE_FIRST = 2'b10
    } cdpr_wmode_e;

    // Values after reset
    localparam cdpr_mode_e  MODE_RST  = CDPR_TRUE;
    localparam cdpr_wmode_e WMODE_RST = CDPR_NO_CHANGE;

endpackage : cdpr_pkg

// ### design/cdpr_ram.sv
// Cascaded dual-port memory with APB control and output pipeline
`timescale 1ns/1ps

module cdpr_ram #(
    parameter int  DEPTH         = 8192,
    parameter int  COPIES        = 1,
    parameter int  GLOBAL_HEIGHT = -1,
    parameter int  MEM_HEIGHT    = -1,
    parameter bit  FULL_PIPE     = 1'b0,
    localparam int W             = cdpr_pkg::TILE_BITS * COPIES, // R2 R18
    localparam int NLANE         = cdpr_pkg::LANES_PER_TILE * COPIES,
    localparam int AW            = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Port A
    input  wire logic             en_a,
    input  wire logic             we_a,
    input  wire logic [NLANE-1:0] bwe_a,
    input  wire logic [AW-1:0]    addr_a,
    input  wire logic [W-1:0]     din_a,
    input  wire logic             rst_a,
    output logic      [W-1:0]     dout_a,
    // Port B
    input  wire logic             en_b,
    input  wire logic             we_b,
    input  wire logic [NLANE-1:0] bwe_b,
    input  wire logic [AW-1:0]    addr_b,
    input  wire logic [W-1:0]     din_b,
    input  wire logic             rst_b,
    output logic      [W-1:0]     dout_b,
    // Status
    output logic                  mem_ready
);

    // Matrix geometry; width only replicates the matrix, never reshapes it
    localparam int TILES  = (DEPTH + cdpr_pkg::TILE_WORDS - 1) / cdpr_pkg::TILE_WORDS; // R16
    localparam int HEIGHT = (MEM_HEIGHT > 0) ? MEM_HEIGHT :                            // R19
                            (GLOBAL_HEIGHT > 0) ? GLOBAL_HEIGHT : cdpr_pkg::DEFAULT_HEIGHT;
    localparam int ROWS   = (TILES < HEIGHT) ? TILES : HEIGHT;                         // R16
    localparam int COLS   = (TILES + HEIGHT - 1) / HEIGHT;                             // R17
    localparam int NST    = FULL_PIPE ? (ROWS + COLS) : 0;                             // R15
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

    // Whole register state of the block
    typedef struct packed {
        cdpr_pkg::cdpr_mode_e  mode;
        cdpr_pkg::cdpr_wmode_e wmode;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  init_busy;
        logic [AW-1:0]         init_addr;
        logic                  ready;
        logic [NST:0][W-1:0]   pa;
        logic [NST:0][W-1:0]   pb;
    } cdpr_state_s;

    cdpr_state_s q;
    cdpr_state_s next_q;

    // Storage array; one clock writes both ports
    logic [W-1:0] mem [DEPTH];

    // Per-cycle port decode
    logic             act_a;
    logic             act_b;
    logic             wr_a;
    logic             wr_b;
    logic             rd_req_a;
    logic             rd_req_b;
    logic [NLANE-1:0] lm_a;
    logic [NLANE-1:0] lm_b;
    logic [W-1:0]     rd_a;
    logic [W-1:0]     rd_b;
    logic [W-1:0]     view_b;

    // Lane mask: word enable gates every byte enable
    function automatic logic [NLANE-1:0] lane_mask(input logic [NLANE-1:0] bwe,
                                                   input logic             wr);
        lane_mask = bwe & {NLANE{wr}}; // R14
    endfunction : lane_mask

    // Merge new lanes over an old word
    function automatic logic [W-1:0] merge(input logic [W-1:0]     old_w,
                                           input logic [W-1:0]     new_w,
                                           input logic [NLANE-1:0] mask);
        logic [W-1:0] r;
        r = old_w;
        for (int l = 0; l < NLANE; l++) begin
            if (mask[l]) begin
                r[l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS] =
                    new_w[l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS]; // R21
            end
        end
        merge = r;
    endfunction : merge

    // Port roles per mode; ports stay dead until the array is cleared
    always_comb begin
        act_a    = q.ready && en_a;                                    // R13
        wr_a     = act_a && we_a;                                      // R13
        rd_req_a = act_a && !we_a && (q.mode != cdpr_pkg::CDPR_SIMPLE); // R9
        act_b    = q.ready && en_b && (q.mode != cdpr_pkg::CDPR_SINGLE); // R8
        wr_b     = act_b && we_b && (q.mode == cdpr_pkg::CDPR_TRUE);   // R9 R10
        rd_req_b = act_b && (!we_b || (q.mode == cdpr_pkg::CDPR_SIMPLE)); // R9
        lm_a     = lane_mask(bwe_a, wr_a);                             // R14
        lm_b     = lane_mask(bwe_b, wr_b);                             // R14
        rd_a     = mem[addr_a];                                        // R3
        rd_b     = mem[addr_b];                                        // R3
        // Port A goes first, so port B sees the word A is writing
        view_b   = (wr_a && (addr_a == addr_b)) ? merge(rd_b, din_a, lm_a) : rd_b; // R11
    end

    // Array update: A lanes first, B lanes after, so B lands last
    always_ff @(posedge pclk) begin // R1
        if (q.init_busy) begin
            mem[q.init_addr] <= '0; // R7
        end
        for (int l = 0; l < NLANE; l++) begin
            if (lm_a[l]) begin
                mem[addr_a][l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS] <=
                    din_a[l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS]; // R14
            end
        end
        for (int l = 0; l < NLANE; l++) begin
            if (lm_b[l]) begin
                mem[addr_b][l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS] <=
                    din_b[l*cdpr_pkg::LANE_BITS +: cdpr_pkg::LANE_BITS]; // R11
            end
        end
    end

    // Next-state logic: APB, clear walk, output registers, pipeline
    always_comb begin
        next_q         = q;
        next_q.pready  = 1'b0;
        next_q.pslverr = 1'b0;

        // Answer in the access phase; read data captured at the setup edge
        if (psel && !penable) begin
            next_q.pready = 1'b1;
            unique case (paddr)
                cdpr_pkg::CTRL_OFS: begin
                    next_q.prdata = 32'h0000_0000;
                    next_q.prdata[cdpr_pkg::CTRL_MODE_LSB +: 2]  = q.mode;
                    next_q.prdata[cdpr_pkg::CTRL_WMODE_LSB +: 2] = q.wmode;
                end
                cdpr_pkg::STATUS_OFS: begin
                    next_q.prdata = 32'h0000_0000;
                    next_q.prdata[cdpr_pkg::STATUS_READY_BIT] = q.ready;
                    next_q.prdata[cdpr_pkg::STATUS_BUSY_BIT]  = q.init_busy;
                end
                cdpr_pkg::GEOM_OFS: begin
                    next_q.prdata = 32'h0000_0000;
                    next_q.prdata[cdpr_pkg::GEOM_ROWS_LSB +: 8]   = 8'(ROWS);
                    next_q.prdata[cdpr_pkg::GEOM_COLS_LSB +: 8]   = 8'(COLS);
                    next_q.prdata[cdpr_pkg::GEOM_STAGES_LSB +: 8] = 8'(NST);
                    next_q.prdata[cdpr_pkg::GEOM_COPIES_LSB +: 8] = 8'(COPIES);
                end
                default: begin
                    next_q.prdata  = 32'h0000_0000;
                    next_q.pslverr = 1'b1;
                end
            endcase
        end

        // Write lands only on the edge that completes the access; illegal codes ignored
        if (psel && penable && q.pready && pwrite && (paddr == cdpr_pkg::CTRL_OFS)) begin
            if (pwdata[cdpr_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
                next_q.mode = cdpr_pkg::cdpr_mode_e'(pwdata[cdpr_pkg::CTRL_MODE_LSB +: 2]);
            end
            if (pwdata[cdpr_pkg::CTRL_WMODE_LSB +: 2] != 2'h3) begin
                next_q.wmode = cdpr_pkg::cdpr_wmode_e'(pwdata[cdpr_pkg::CTRL_WMODE_LSB +: 2]);
            end
        end

        // Clear walk after reset; the array has no preload of its own
        if (q.init_busy) begin
            next_q.init_addr = AW'(q.init_addr + 1'b1); // R7
            if (q.init_addr == LAST_ADDR) begin
                next_q.init_busy = 1'b0;
                next_q.ready     = 1'b1;
            end
        end

        // Pipeline shifts every cycle except on an output reset, which clears every stage; stage 0 is the tile output register
        for (int s = 1; s <= NST; s++) begin
            next_q.pa[s] = q.pa[s-1]; // R15
            next_q.pb[s] = q.pb[s-1]; // R15
        end

        // Port A output register
        if (rst_a) begin
            next_q.pa = '0; // R4
        end else if (wr_a) begin
            // Read-first and write-first exist only as surrounding logic in single-port
            if (q.mode == cdpr_pkg::CDPR_SINGLE) begin
                unique case (q.wmode)
                    cdpr_pkg::CDPR_NO_CHANGE:   next_q.pa[0] = q.pa[0];                // R5
                    cdpr_pkg::CDPR_READ_FIRST:  next_q.pa[0] = rd_a;                   // R6
                    cdpr_pkg::CDPR_WRITE_FIRST: next_q.pa[0] = merge(rd_a, din_a, lm_a); // R6
                endcase
            end
        end else if (rd_req_a) begin
            next_q.pa[0] = rd_a; // R20
        end

        // Port B output register; a B write leaves it alone
        if (rst_b) begin
            next_q.pb = '0; // R4
        end else if (rd_req_b) begin
            next_q.pb[0] = view_b; // R11 R20
        end
    end

    // State register; async reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.mode      <= cdpr_pkg::MODE_RST;
            q.wmode     <= cdpr_pkg::WMODE_RST;
            q.init_busy <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign dout_a    = q.pa[NST];
    assign dout_b    = q.pb[NST];
    assign mem_ready = q.ready;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_apb_answer;
        psel && !penable |=> pready && (prdata == $past(next_q.prdata));
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer missing");

    property p_no_change;
        wr_a && !rst_a && (q.mode == cdpr_pkg::CDPR_TRUE) |=> $stable(q.pa[0]);
    endproperty
    a_no_change: assert property (p_no_change) else $error("A output moved on write"); // R5

    property p_out_reset;
        rst_b |=> (dout_b == '0);
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("B output not cleared"); // R4

    property p_read_latency;
        rd_req_a && !rst_a |=> (q.pa[0] == $past(rd_a));
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("A read data late"); // R20

    property p_a_first;
        wr_a && lm_a[0] && rd_req_b && !rst_b && (addr_a == addr_b)
            |=> (q.pb[0][8:0] == $past(din_a[8:0]));
    endproperty
    a_a_first: assert property (p_a_first) else $error("B missed A write"); // R11

    property p_lane_keep;
        (wr_a && !bwe_a[0] && !wr_b) ##1
        (rd_req_a && !rst_a && !wr_b && (addr_a == $past(addr_a)))
            |=> (q.pa[0][8:0] == $past(rd_a[8:0], 2));
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("Unselected lane written"); // R14

    property p_disabled;
        !en_a && !rst_a |=> $stable(q.pa[0]);
    endproperty
    a_disabled: assert property (p_disabled) else $error("Disabled port acted"); // R13

    property p_single_b;
        (q.mode == cdpr_pkg::CDPR_SINGLE) && !rst_b |=> $stable(q.pb[0]);
    endproperty
    a_single_b: assert property (p_single_b) else $error("B active in single-port"); // R8

    property p_simple_a;
        (q.mode == cdpr_pkg::CDPR_SIMPLE) && !rst_a |=> $stable(q.pa[0]);
    endproperty
    a_simple_a: assert property (p_simple_a) else $error("A read in simple mode"); // R9

    property p_init;
        $rose(q.ready) |-> ($past(q.init_addr) == LAST_ADDR) && !q.init_busy;
    endproperty
    a_init: assert property (p_init) else $error("Ready before clear walk ended"); // R7

    property p_rst_a;
        rst_a |=> (dout_a == '0);
    endproperty
    a_rst_a: assert property (p_rst_a) else $error("A output not cleared"); // R4

    property p_en_b;
        !en_b && !rst_b |=> $stable(q.pb[0]);
    endproperty
    a_en_b: assert property (p_en_b) else $error("Disabled port B acted"); // R13

    // Surrounding logic has to mimic the write modes the array itself lacks
    property p_read_first;
        wr_a && !rst_a && (q.mode == cdpr_pkg::CDPR_SINGLE) &&
            (q.wmode == cdpr_pkg::CDPR_READ_FIRST) |=> (q.pa[0] == $past(rd_a));
    endproperty
    a_read_first: assert property (p_read_first) else $error("Read-first word wrong"); // R6

    property p_write_first;
        wr_a && lm_a[0] && !rst_a && (q.mode == cdpr_pkg::CDPR_SINGLE) &&
            (q.wmode == cdpr_pkg::CDPR_WRITE_FIRST)
            |=> (q.pa[0][8:0] == $past(din_a[8:0]));
    endproperty
    a_write_first: assert property (p_write_first) else $error("Write-first word wrong"); // R6

    property p_lane_b;
        wr_a && !lm_a[0] && rd_req_b && !rst_b && (addr_a == addr_b)
            |=> (q.pb[0][8:0] == $past(rd_b[8:0]));
    endproperty
    a_lane_b: assert property (p_lane_b) else $error("B saw an unselected A lane"); // R11 R14

    // The zero walk must not hand the ports over before its last address
    property p_walk;
        q.init_busy && (q.init_addr != LAST_ADDR) |=> q.init_busy && !q.ready;
    endproperty
    a_walk: assert property (p_walk) else $error("Clear walk ended early"); // R7

    // An illegal mode code must leave the running mode alone
    property p_mode_hold;
        psel && penable && q.pready && pwrite && (paddr == cdpr_pkg::CTRL_OFS) &&
            (pwdata[cdpr_pkg::CTRL_MODE_LSB +: 2] == 2'h3) |=> $stable(q.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("Illegal mode code taken");

    // Added stages delay stage 0 by exactly their count
    if (NST > 0) begin : g_pipe_chk
        property p_pipe;
            !rst_a |=> (dout_a == $past(q.pa[NST-1]));
        endproperty
        a_pipe: assert property (p_pipe) else $error("Pipeline depth wrong"); // R15
    end

endmodule : cdpr_ram

// ### sim/cdpr_ram_tb.sv
// Self-checking testbench for the cascaded dual-port memory
`timescale 1ns/1ps

module cdpr_ram_tb;
    localparam int D = 64;
    localparam int DP = 16384;
    logic [31:0]           prdata_p, rdp;
    logic [71:0]           dout_a_p, dout_b_p;
    logic [15:0]           gp;
    logic                  mem_ready_p;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ready, er;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic                  en_a, we_a, rst_a, en_b, we_b, rst_b;
    logic [7:0]            bwe_a, bwe_b;
    logic [5:0]            addr_a, addr_b, aa, ab;
    logic [71:0]           din_a, din_b, dout_a, dout_b, exp_a, exp_b;
    logic [71:0]           ref_mem [D];
    logic [3:0]            cfg [5] = '{4'h2, 4'h1, 4'h0, 4'h4, 4'h8};
    cdpr_pkg::cdpr_mode_e  mode;
    cdpr_pkg::cdpr_wmode_e wmode;
    int                    fail_count = 0;
    int                    checks_done = 0;

    cdpr_ram #(.DEPTH(D)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .en_a, .we_a, .bwe_a, .addr_a, .din_a, .rst_a, .dout_a,
        .en_b, .we_b, .bwe_b, .addr_b, .din_b, .rst_b, .dout_b, .mem_ready);
    cdpr_user #(.AW(6)) i_user (.pclk, .en_a, .we_a, .bwe_a, .addr_a, .din_a, .rst_a,
        .en_b, .we_b, .bwe_b, .addr_b, .din_b, .rst_b);
    // Deep, height-limited, fully pipelined copy on the same buses
    cdpr_ram #(.DEPTH(DP), .GLOBAL_HEIGHT(5), .MEM_HEIGHT(3), .FULL_PIPE(1'b1)) i_dut_p (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_p),
        .pready(), .pslverr(), .en_a, .we_a, .bwe_a, .addr_a({8'h00, addr_a}), .din_a,
        .rst_a, .dout_a(dout_a_p), .en_b, .we_b, .bwe_b, .addr_b({8'h00, addr_b}), .din_b,
        .rst_b, .dout_b(dout_b_p), .mem_ready(mem_ready_p));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Whole run is under 20k cycles, dominated by the deep clear walk
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end

    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // APB transfer; the slave answers in the first access cycle, and pready is polled with no bound of its own
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rdp = prdata_p;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [71:0] merge(input logic [71:0] o, n, input logic [7:0] m);
        for (int l = 0; l < 8; l++)
            if (m[l]) o[9*l +: 9] = n[9*l +: 9];
        return o;
    endfunction : merge

    // Expected {cols, rows} of the tile matrix
    function automatic logic [15:0] geom(input int depth, input int h);
        int t = (depth + cdpr_pkg::TILE_WORDS - 1) / cdpr_pkg::TILE_WORDS;
        return {8'((t + h - 1) / h), 8'((t < h) ? t : h)};
    endfunction : geom

    // One random cycle on both ports, then the reference update
    task automatic step(input logic [5:0] aa, ab, input logic [10:0] fa, fb);
        logic [10:0] ca, cb;
        logic [71:0] da, db, old;
        ca = (fa != 11'h0) ? fa : 11'($urandom) & 11'h6FF;
        cb = (fb != 11'h0) ? fb : 11'($urandom) & 11'h6FF;
        da = 72'({$urandom, $urandom, $urandom});
        db = 72'({$urandom, $urandom, $urandom});
        i_user.op(ca, aa, da, cb, ab, db);
        #1;
        // Port A acts first, so port B sees its write in the same cycle
        if (ca[10] && (ca[9] || mode != cdpr_pkg::CDPR_SIMPLE)) begin
            old = ref_mem[aa];
            if (!ca[9]) begin
                exp_a = old;
            end else begin
                ref_mem[aa] = merge(old, da, ca[7:0]);
                if (wmode == cdpr_pkg::CDPR_READ_FIRST) exp_a = old;
                if (wmode == cdpr_pkg::CDPR_WRITE_FIRST) exp_a = ref_mem[aa];
            end
        end
        if (cb[10] && mode != cdpr_pkg::CDPR_SINGLE) begin
            if (cb[9] && mode == cdpr_pkg::CDPR_TRUE) ref_mem[ab] = merge(ref_mem[ab], db, cb[7:0]);
            else exp_b = ref_mem[ab];
        end
        check(dout_a, exp_a);
        check(dout_b, exp_b);
    endtask : step

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        {exp_a, exp_b} = '0;
        foreach (ref_mem[i]) ref_mem[i] = '0;
        void'($urandom(43));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // The deep copy clears last, so its ready ends the wait
        for (int n = 0; n < 2 * DP && mem_ready_p !== 1'b1; n++) @(posedge pclk);
        check(mem_ready, 1'b1);
        check(mem_ready_p, 1'b1);
        apb(1'b0, cdpr_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, cdpr_pkg::GEOM_OFS, 32'h0);
        check(rd, {8'h1, 8'h0, geom(D, cdpr_pkg::DEFAULT_HEIGHT)});
        gp = geom(DP, 3);
        check(rdp, {8'h1, 8'(gp[15:8] + gp[7:0]), gp});
        apb(1'b0, 12'h00C, 32'h0);
        check({er, rd}, 33'h100000000);
        // Code 3 in either field is ignored, so the reset values stay
        apb(1'b1, cdpr_pkg::CTRL_OFS, 32'h0000_000F);
        apb(1'b0, cdpr_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'({cdpr_pkg::WMODE_RST, cdpr_pkg::MODE_RST}));
        $display("register checks finished");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, cdpr_pkg::CTRL_OFS, {28'h0, cfg[i]});
            apb(1'b0, cdpr_pkg::CTRL_OFS, 32'h0);
            check(rd, {28'h0, cfg[i]});
            mode = cdpr_pkg::cdpr_mode_e'(cfg[i][1:0]);
            wmode = cdpr_pkg::cdpr_wmode_e'(cfg[i][3:2]);
            // Corner cases: a disabled write, then a same-address pair where defined
            step(6'h3F, 6'h3E, 11'h2FF, 11'h2FF);
            if (mode == cdpr_pkg::CDPR_SIMPLE) step(6'h05, 6'h05, 11'h6FE, 11'h4FF);
            repeat (40) begin
                aa = ($urandom % 8 == 0) ? 6'h3F : 6'($urandom);
                // Same-address collisions only where the outcome is defined
                ab = (mode == cdpr_pkg::CDPR_TRUE) ? aa ^ 6'(1 + $urandom % 63) :
                     (($urandom % 4 == 0) ? aa : 6'($urandom));
                step(aa, ab, 11'h0, 11'h0);
            end
            if (mode == cdpr_pkg::CDPR_TRUE) begin
                // Output reset wins over a read issued with it
                i_user.op(11'h500, 6'h00, 72'h0, 11'h500, 6'h01, 72'h0);
                #1;
                {exp_a, exp_b} = '0;
                check(dout_a, 72'h0);
                check(dout_b, 72'h0);
                check(dout_a_p, 72'h0);
                check(dout_b_p, 72'h0);
            end
            $display("config %0d finished", i);
        end
        final_report();
    end

endmodule : cdpr_ram_tb

// ### sim/cdpr_user.sv
// User logic model that drives both memory ports of the cascaded memory
`timescale 1ns/1ps

module cdpr_user #(
    parameter int AW = 6
) (
    // Clock
    input  wire logic          pclk,
    // Port A
    output logic               en_a,
    output logic               we_a,
    output logic [7:0]         bwe_a,
    output logic [AW-1:0]      addr_a,
    output logic [71:0]        din_a,
    output logic               rst_a,
    // Port B
    output logic               en_b,
    output logic               we_b,
    output logic [7:0]         bwe_b,
    output logic [AW-1:0]      addr_b,
    output logic [71:0]        din_b,
    output logic               rst_b
);

    // Idle from time zero so nothing is requested during reset
    initial begin
        {en_a, we_a, bwe_a, addr_a, din_a, rst_a} = '0;
        {en_b, we_b, bwe_b, addr_b, din_b, rst_b} = '0;
    end

    // One request on both ports, control packed as enable, write, reset, lanes
    task automatic op(input logic [10:0] ca, input logic [AW-1:0] aa, input logic [71:0] da,
                      input logic [10:0] cb, input logic [AW-1:0] ab, input logic [71:0] db);
        @(posedge pclk);
        {en_a, we_a, rst_a, bwe_a} <= ca;
        addr_a                     <= aa;
        din_a                      <= da;
        {en_b, we_b, rst_b, bwe_b} <= cb;
        addr_b                     <= ab;
        din_b                      <= db;
        @(posedge pclk);
        // Released data lines flip so a stale word can never pass for a fresh one
        {en_a, we_a, rst_a} <= 3'h0;
        din_a               <= ~da;
        {en_b, we_b, rst_b} <= 3'h0;
        din_b               <= ~db;
    endtask : op

endmodule : cdpr_user
